// >>> rtl/blc_top.sv
// Overview of operation
// - tx zero-suppress disable 0: B3ZS/HDB3 substitution plus AMI; 1: AMI only
// - excess-zero inject enable adds excessive-zero events to injected errors
// - bipolar-violation inject enable adds BPVs to injected errors
// - with register trigger selected, each 0-to-1 of trigger inserts one error
// - trigger must drop and rise again; several edges before use give one error
// - error source select: 0 register trigger bit, 1 external trigger pin
// - e3 select counts same-polarity consecutive violations instead of BPVs
// - e3 select ignored in B3ZS mode
// - error-detect format 1 demands signature violation polarity alternation
// - decode format bit selects the same two signature forms for decoding
// - after reset the first signature ignores both format bits
// - rx zero-suppress disable 0: undo substitution and AMI; 1: AMI only
// - live excess-zero flag is one while excess-zero count is nonzero
// - live violation flag is one while violation count is nonzero
// - live signal-absent bit follows the loss-of-signal condition
// - rx zero-suppress disabled forces loss-of-signal clear
// - codeword latched flag sets on each recognised signature
// - excess-zero latched flag sets on each excessive-zero event
// - count latched flags set when live count flags rise
// - violation latched flag sets on each counted violation
// - signal-absent latched flag sets on any change of live state
// - 16-bit violation counter, readable copy refreshed by update
module blc_top (
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  input  wire logic [blc_pkg::ADDR_W-1:0]   paddr,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [31:0]                  pwdata,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  input  wire logic                         tx_data,
  input  wire logic                         tx_bit_en,
  input  wire logic                         ext_error_trigger_pin,
  output blc_pkg::blc_bip_t                 tx_line,
  input  wire blc_pkg::blc_bip_t            rx_line,
  input  wire logic                         rx_bit_en,
  output logic                              rx_data,
  output logic                              rx_data_valid
);

  logic [blc_pkg::TX_CTRL_W-1:0] tx_ctrl_reg;
  logic [blc_pkg::RX_CTRL_W-1:0] rx_ctrl_reg;
  logic [blc_pkg::LAT_W-1:0]     lat_reg, lat_set, lat_clr, irq_en_reg;
  logic                          hdb3_reg;
  logic [blc_pkg::CNT_W-1:0]     bpv_run_reg, exz_run_reg, bpv_snap_reg, exz_snap_reg;
  logic [3:0]                    sync1_reg, sync2_reg;
  logic                          wr_fire, pm_pulse, rd_start;
  logic [31:0]                   rd_word;
  logic                          rd_hit;

  // two-stage synchronisers for pin inputs; only stage two is read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= 4'h0;
      sync2_reg <= 4'h0;
    end else begin
      sync1_reg <= {ext_error_trigger_pin, rx_line.pos, rx_line.neg, rx_bit_en};
      sync2_reg <= sync1_reg;
    end
  end

  wire ext_trig_s = sync2_reg[3];
  wire rx_pos_s   = sync2_reg[2];
  wire rx_neg_s   = sync2_reg[1];
  wire rx_en_s    = sync2_reg[0];

  function automatic logic hit(input logic [blc_pkg::ADDR_W-1:0] a, input logic [7:0] idx);
    return a == blc_pkg::reg_addr(idx);
  endfunction : hit

  // apb: one wait state, so pready rises in the second access cycle
  assign rd_start = psel & penable & ~pready;
  assign wr_fire  = psel & penable & pready & pwrite;
  assign pm_pulse = wr_fire & hit(paddr, blc_pkg::IDX_PM_UPDATE) & pwdata[0];
  assign lat_clr  = (wr_fire & hit(paddr, blc_pkg::IDX_RX_STAT_L)) ? pwdata[blc_pkg::LAT_W-1:0] : '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= rd_start;
      pslverr <= rd_start & ~rd_hit;
      prdata  <= (rd_start & ~pwrite) ? rd_word : 32'h0000_0000;
    end
  end

  // writable control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_ctrl_reg <= blc_pkg::TX_CTRL_RST;
      rx_ctrl_reg <= blc_pkg::RX_CTRL_RST;
      irq_en_reg  <= blc_pkg::LAT_RST;
      hdb3_reg    <= 1'b0;
    end else if (wr_fire) begin
      if (hit(paddr, blc_pkg::IDX_TX_CTRL))   tx_ctrl_reg <= pwdata[blc_pkg::TX_CTRL_W-1:0];
      if (hit(paddr, blc_pkg::IDX_RX_CTRL))   rx_ctrl_reg <= pwdata[blc_pkg::RX_CTRL_W-1:0];
      if (hit(paddr, blc_pkg::IDX_RX_IRQ_EN)) irq_en_reg  <= pwdata[blc_pkg::LAT_W-1:0];
      if (hit(paddr, blc_pkg::IDX_LINE_MODE)) hdb3_reg    <= pwdata[0];
    end
  end

  // ---------------- transmit encoder ----------------
  blc_pkg::blc_sym_t enc_sr [4];
  blc_pkg::blc_sym_t enc_win [4];
  logic              enc_par_reg, enc_par_next, tx_last_reg;
  logic              trig_prev_reg, bpv_pend_reg, exz_pend_reg;
  logic              trig_src, trig_edge, sub_do, exz_use, bpv_use, zrun;

  // trigger source mux and rising-edge catch
  assign trig_src  = tx_ctrl_reg[blc_pkg::TX_SRC_BIT] ? ext_trig_s : tx_ctrl_reg[blc_pkg::TX_TRIG_BIT];
  assign trig_edge = trig_src & ~trig_prev_reg;

  // window of the newest four symbols, with substitution applied
  always_comb begin
    enc_win[0]   = tx_data ? blc_pkg::SYM_ONE : blc_pkg::SYM_ZERO;
    enc_win[1]   = enc_sr[0];
    enc_win[2]   = enc_sr[1];
    enc_win[3]   = enc_sr[2];
    enc_par_next = enc_par_reg ^ tx_data;
    zrun = enc_win[0] == blc_pkg::SYM_ZERO && enc_win[1] == blc_pkg::SYM_ZERO
           && enc_win[2] == blc_pkg::SYM_ZERO && (!hdb3_reg || enc_win[3] == blc_pkg::SYM_ZERO);
    sub_do  = zrun & ~tx_ctrl_reg[blc_pkg::TX_ZSD_BIT];
    exz_use = sub_do & exz_pend_reg; // skipped codeword leaves a long zero run
    if (sub_do) begin
      enc_win[0] = exz_use ? blc_pkg::SYM_CZERO : blc_pkg::SYM_VIOL;
      enc_win[1] = blc_pkg::SYM_CZERO;
      enc_win[2] = blc_pkg::SYM_CZERO;
      if (hdb3_reg) enc_win[3] = blc_pkg::SYM_CZERO;
      // even pulse count since last violation needs a balancing pulse first
      if (!exz_use && !enc_par_reg) begin
        if (hdb3_reg) enc_win[3] = blc_pkg::SYM_ONE;
        else          enc_win[2] = blc_pkg::SYM_ONE;
      end
      if (!exz_use) enc_par_next = 1'b0;
    end
  end

  assign bpv_use = tx_bit_en & bpv_pend_reg & (enc_sr[3] == blc_pkg::SYM_ONE);

  // pending requests: a new edge wins over the use in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_prev_reg <= 1'b0;
      bpv_pend_reg  <= 1'b0;
      exz_pend_reg  <= 1'b0;
    end else begin
      trig_prev_reg <= trig_src;
      if (trig_edge & tx_ctrl_reg[blc_pkg::TX_BIPOLAR_VIOL_INJECT_EN_BIT])      bpv_pend_reg <= 1'b1;
      else if (bpv_use)                                       bpv_pend_reg <= 1'b0;
      if (trig_edge & tx_ctrl_reg[blc_pkg::TX_EXCESS_ZERO_INJECT_EN_BIT])      exz_pend_reg <= 1'b1;
      else if (tx_bit_en & exz_use)                           exz_pend_reg <= 1'b0;
    end
  end

  // shift pipeline and ami polarity output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 4; i++) enc_sr[i] <= blc_pkg::SYM_ZERO;
      enc_par_reg <= 1'b0;
      tx_last_reg <= 1'b0;
      tx_line     <= '0;
    end else if (tx_bit_en) begin
      for (int i = 0; i < 4; i++) enc_sr[i] <= enc_win[i];
      enc_par_reg <= enc_par_next;
      unique case (enc_sr[3])
        blc_pkg::SYM_ONE: begin
          // injected violation repeats the last polarity
          tx_line     <= bpv_use ? {tx_last_reg, ~tx_last_reg} : {~tx_last_reg, tx_last_reg};
          tx_last_reg <= bpv_use ? tx_last_reg : ~tx_last_reg;
        end
        blc_pkg::SYM_VIOL: tx_line <= {tx_last_reg, ~tx_last_reg};
        blc_pkg::SYM_ZERO, blc_pkg::SYM_CZERO: tx_line <= '0;
      endcase
    end
  end

  // ---------------- receive decoder ----------------
  logic       rx_mark, rx_pol, is_v, dec_sig, err_sig, bpv_ev, lcv_ev, count_ev, exz_ev;
  logic       rx_last_reg, seen_reg, vseen_reg, vpol_reg;
  logic       dec_first_reg, dec_pol_reg, err_first_reg, err_pol_reg;
  logic [3:0] zc_reg, zreq, exz_thr;
  logic [7:0] los_cnt_reg;
  logic [3:0] dec_sr;
  logic       los_next, signal_absent_reg;

  assign rx_mark = rx_pos_s ^ rx_neg_s;
  assign rx_pol  = rx_pos_s;
  assign zreq    = hdb3_reg ? 4'h2 : 4'h1;
  assign exz_thr = hdb3_reg ? blc_pkg::EXZ_HDB3 : blc_pkg::EXZ_B3ZS;
  assign is_v    = rx_en_s & rx_mark & seen_reg & (rx_pol == rx_last_reg);

  // signature checks; first one after reset ignores the format bits
  assign dec_sig = is_v & ~rx_ctrl_reg[blc_pkg::RX_ZSD_BIT] & (zc_reg >= zreq)
                   & (dec_first_reg | ~rx_ctrl_reg[blc_pkg::RX_DFMT_BIT] | (rx_pol != dec_pol_reg));
  assign err_sig = is_v & (zc_reg >= zreq)
                   & (err_first_reg | ~rx_ctrl_reg[blc_pkg::RX_EFMT_BIT] | (rx_pol != err_pol_reg));
  assign bpv_ev   = is_v & ~err_sig;
  assign lcv_ev   = is_v & vseen_reg & (rx_pol == vpol_reg);
  assign count_ev = (hdb3_reg & rx_ctrl_reg[blc_pkg::RX_E3_BIT]) ? lcv_ev : bpv_ev;
  assign exz_ev   = rx_en_s & ~rx_mark & (zc_reg + 4'h1 == exz_thr);
  assign los_next = rx_ctrl_reg[blc_pkg::RX_ZSD_BIT] ? 1'b0 :
                    rx_en_s ? (!rx_mark && los_cnt_reg >= blc_pkg::LOS_ZEROS - 8'h01) : signal_absent_reg;

  // line tracking state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_last_reg   <= 1'b0;
      seen_reg      <= 1'b0;
      vseen_reg     <= 1'b0;
      vpol_reg      <= 1'b0;
      dec_first_reg <= 1'b1;
      dec_pol_reg   <= 1'b0;
      err_first_reg <= 1'b1;
      err_pol_reg   <= 1'b0;
      zc_reg        <= 4'h0;
      los_cnt_reg   <= 8'h00;
      signal_absent_reg <= 1'b0;
    end else begin
      signal_absent_reg <= los_next;
      if (rx_en_s) begin
        if (rx_mark) begin
          rx_last_reg <= rx_pol;
          seen_reg    <= 1'b1;
          zc_reg      <= 4'h0;
          los_cnt_reg <= 8'h00;
        end else begin
          if (zc_reg != 4'hf)        zc_reg      <= zc_reg + 4'h1;
          if (los_cnt_reg != 8'hff)  los_cnt_reg <= los_cnt_reg + 8'h01;
        end
        if (is_v) begin
          vseen_reg <= 1'b1;
          vpol_reg  <= rx_pol;
        end
        if (dec_sig) begin
          dec_first_reg <= 1'b0;
          dec_pol_reg   <= rx_pol;
        end
        if (err_sig) begin
          err_first_reg <= 1'b0;
          err_pol_reg   <= rx_pol;
        end
      end
    end
  end

  // decoded data delay line; a signature zeroes itself and its pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dec_sr        <= 4'h0;
      rx_data       <= 1'b0;
      rx_data_valid <= 1'b0;
    end else begin
      rx_data_valid <= rx_en_s;
      if (rx_en_s) begin
        rx_data <= dec_sr[3];
        dec_sr  <= {dec_sr[2:0], rx_mark & ~dec_sig};
        if (dec_sig) dec_sr <= {dec_sr[2] & ~hdb3_reg, 3'b000}; // b3zs keeps the bit ahead of its codeword
      end
    end
  end

  // running counters; update copies them out and restarts
  function automatic logic [blc_pkg::CNT_W-1:0] sat_inc(input logic [blc_pkg::CNT_W-1:0] c, input logic ev);
    return (ev && c != 16'hffff) ? c + 16'h0001 : c;
  endfunction : sat_inc

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bpv_run_reg  <= 16'h0000;
      exz_run_reg  <= 16'h0000;
      bpv_snap_reg <= 16'h0000;
      exz_snap_reg <= 16'h0000;
    end else if (pm_pulse) begin
      bpv_snap_reg <= sat_inc(bpv_run_reg, count_ev);
      exz_snap_reg <= sat_inc(exz_run_reg, exz_ev);
      bpv_run_reg  <= {15'h0000, count_ev};
      exz_run_reg  <= {15'h0000, exz_ev};
    end else begin
      bpv_run_reg <= sat_inc(bpv_run_reg, count_ev);
      exz_run_reg <= sat_inc(exz_run_reg, exz_ev);
    end
  end

  // live flags and latched status
  logic exz_live, bpv_live, exz_live_prev_reg, bpv_live_prev_reg;
  assign exz_live = exz_run_reg != 16'h0000;
  assign bpv_live = bpv_run_reg != 16'h0000;

  always_comb begin
    lat_set                       = '0;
    lat_set[blc_pkg::LT_CW_BIT]   = dec_sig;
    lat_set[blc_pkg::LT_EXZ_BIT]  = exz_ev;
    lat_set[blc_pkg::LT_EXCESS_ZERO_FLAG_BIT] = exz_live & ~exz_live_prev_reg;
    lat_set[blc_pkg::LT_BPV_BIT]  = count_ev;
    lat_set[blc_pkg::LT_BIPOLAR_VIOL_FLAG_BIT] = bpv_live & ~bpv_live_prev_reg;
    lat_set[blc_pkg::LT_LOS_BIT]  = los_next != signal_absent_reg;
  end

  // set wins over a simultaneous write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lat_reg           <= blc_pkg::LAT_RST;
      exz_live_prev_reg <= 1'b0;
      bpv_live_prev_reg <= 1'b0;
    end else begin
      lat_reg           <= (lat_reg & ~lat_clr) | lat_set;
      exz_live_prev_reg <= exz_live;
      bpv_live_prev_reg <= bpv_live;
    end
  end

  // read mux; unmapped addresses read zero and flag an error
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    if (hit(paddr, blc_pkg::IDX_TX_CTRL))        rd_word[blc_pkg::TX_CTRL_W-1:0] = tx_ctrl_reg;
    else if (hit(paddr, blc_pkg::IDX_RX_CTRL))   rd_word[blc_pkg::RX_CTRL_W-1:0] = rx_ctrl_reg;
    else if (hit(paddr, blc_pkg::IDX_RX_STAT)) begin
      rd_word[blc_pkg::ST_EXZ_BIT] = exz_live;
      rd_word[blc_pkg::ST_BPV_BIT] = bpv_live;
      rd_word[blc_pkg::ST_LOS_BIT] = signal_absent_reg;
    end
    else if (hit(paddr, blc_pkg::IDX_RX_STAT_L)) rd_word[blc_pkg::LAT_W-1:0] = lat_reg;
    else if (hit(paddr, blc_pkg::IDX_RX_IRQ_EN)) rd_word[blc_pkg::LAT_W-1:0] = irq_en_reg;
    else if (hit(paddr, blc_pkg::IDX_BPV_CNT))   rd_word[blc_pkg::CNT_W-1:0] = bpv_snap_reg;
    else if (hit(paddr, blc_pkg::IDX_EXZ_CNT))   rd_word[blc_pkg::CNT_W-1:0] = exz_snap_reg;
    else if (hit(paddr, blc_pkg::IDX_LINE_MODE)) rd_word[0] = hdb3_reg;
    else if (!hit(paddr, blc_pkg::IDX_PM_UPDATE)) rd_hit = 1'b0;
  end

  // ---------------- checks ----------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ami_only_tx: assert property (tx_ctrl_reg[blc_pkg::TX_ZSD_BIT] |-> !sub_do)
    else $error("substitution while zero suppression disabled");
  a_bpv_req_held: assert property (trig_edge && tx_ctrl_reg[blc_pkg::TX_BIPOLAR_VIOL_INJECT_EN_BIT] |=> bpv_pend_reg)
    else $error("violation request lost");
  a_exz_req_held: assert property (trig_edge && tx_ctrl_reg[blc_pkg::TX_EXCESS_ZERO_INJECT_EN_BIT] |=> exz_pend_reg)
    else $error("excess zero request lost");
  a_level_no_edge: assert property (trig_edge |=> !trig_edge)
    else $error("held trigger produced an edge");
  a_e3_b3zs_off: assert property (!hdb3_reg |-> count_ev == bpv_ev)
    else $error("e3 counting active in b3zs mode");
  a_los_forced: assert property (rx_ctrl_reg[blc_pkg::RX_ZSD_BIT] |=> !signal_absent_reg)
    else $error("loss of signal while decoding disabled");
  a_codeword_latch: assert property (dec_sig |=> lat_reg[blc_pkg::LT_CW_BIT])
    else $error("codeword not latched");
  a_los_change_latch: assert property ($changed(signal_absent_reg) |-> lat_reg[blc_pkg::LT_LOS_BIT])
    else $error("loss of signal change not latched");
  a_latch_hold: assert property (1'b1 |=> ((lat_reg & $past(lat_reg & ~lat_clr)) == $past(lat_reg & ~lat_clr)))
    else $error("latched flag dropped without clear");
  a_count_flag_zero: assert property (pm_pulse && !count_ev ##1 !count_ev |=> !bpv_live)
    else $error("violation flag set with zero count");

  c_codeword: cover property (dec_sig);
  c_bpv_inject: cover property (bpv_use);
  c_exz_inject: cover property (tx_bit_en && exz_use);
  c_los_rise: cover property ($rose(signal_absent_reg));
endmodule : blc_top

// >>> rtl/blc_pkg.sv
package blc_pkg;

  // bus geometry
  localparam int unsigned ADDR_W = 12;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_LINE_MODE  = 8'h80;
  localparam logic [7:0] IDX_PM_UPDATE  = 8'h82;
  localparam logic [7:0] IDX_TX_CTRL    = 8'h8c;
  localparam logic [7:0] IDX_RX_CTRL    = 8'h90;
  localparam logic [7:0] IDX_RX_STAT    = 8'h94;
  localparam logic [7:0] IDX_RX_STAT_L  = 8'h96;
  localparam logic [7:0] IDX_RX_IRQ_EN  = 8'h98;
  localparam logic [7:0] IDX_BPV_CNT    = 8'h9c;
  localparam logic [7:0] IDX_EXZ_CNT    = 8'h9e;

  // line_tx_control fields
  localparam int unsigned TX_ZSD_BIT  = 4;
  localparam int unsigned TX_EXCESS_ZERO_INJECT_EN_BIT = 3;
  localparam int unsigned TX_BIPOLAR_VIOL_INJECT_EN_BIT = 2;
  localparam int unsigned TX_TRIG_BIT = 1;
  localparam int unsigned TX_SRC_BIT  = 0;
  localparam int unsigned TX_CTRL_W   = 5;
  localparam logic [TX_CTRL_W-1:0] TX_CTRL_RST = 5'h00;

  // line_rx_control fields
  localparam int unsigned RX_E3_BIT   = 3;
  localparam int unsigned RX_EFMT_BIT = 2;
  localparam int unsigned RX_DFMT_BIT = 1;
  localparam int unsigned RX_ZSD_BIT  = 0;
  localparam int unsigned RX_CTRL_W   = 4;
  localparam logic [RX_CTRL_W-1:0] RX_CTRL_RST = 4'h0;

  // status and latched status fields
  localparam int unsigned ST_EXZ_BIT  = 3;
  localparam int unsigned ST_BPV_BIT  = 1;
  localparam int unsigned ST_LOS_BIT  = 0;
  localparam int unsigned LT_CW_BIT   = 5;
  localparam int unsigned LT_EXZ_BIT  = 4;
  localparam int unsigned LT_EXCESS_ZERO_FLAG_BIT = 3;
  localparam int unsigned LT_BPV_BIT  = 2;
  localparam int unsigned LT_BIPOLAR_VIOL_FLAG_BIT = 1;
  localparam int unsigned LT_LOS_BIT  = 0;
  localparam int unsigned LAT_W       = 6;
  localparam logic [LAT_W-1:0] LAT_RST = 6'h00;

  // counters and line thresholds
  localparam int unsigned CNT_W      = 16;
  localparam logic [3:0]  EXZ_B3ZS   = 4'h3;
  localparam logic [3:0]  EXZ_HDB3   = 4'h4;
  localparam logic [7:0]  LOS_ZEROS  = 8'haf;

  typedef enum logic [1:0] {SYM_ZERO, SYM_CZERO, SYM_ONE, SYM_VIOL} blc_sym_t;

  typedef struct packed {
    logic pos;
    logic neg;
  } blc_bip_t;

  function automatic logic [ADDR_W-1:0] reg_addr(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction : reg_addr

endpackage : blc_pkg

// >>> tb/blc_line_model.sv
module blc_line_model (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              tx_bit_en,
  input  wire blc_pkg::blc_bip_t tx_line,
  output blc_pkg::blc_bip_t      rx_line,
  output logic                   rx_bit_en
);
  timeunit 1ns;
  timeprecision 1ps;
  // loopback: line strobe trails the framer strobe by the tx register stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) rx_bit_en <= 1'h0;
    else rx_bit_en <= tx_bit_en;
  end
  // pins are not held between strobes: inverse, so a stale sample never passes
  assign rx_line = rx_bit_en ? tx_line : ~tx_line;
endmodule : blc_line_model

// >>> tb/blc_top_tb.sv
module blc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                       pclk    = 1'h0;
  logic                       presetn = 1'h0;
  logic [blc_pkg::ADDR_W-1:0] paddr   = '0;
  logic                       psel    = 1'h0;
  logic                       penable = 1'h0;
  logic                       pwrite  = 1'h0;
  logic [31:0]                pwdata  = '0;
  logic                       tx_data = 1'h0;
  logic                       tx_bit_en = 1'h0;
  logic                       ext_pin = 1'h0;
  logic                       chk_on  = 1'h0;
  logic [1:0]                 mode    = 2'h0;
  logic [31:0]                prdata, rd, wv;
  logic                       pready, pslverr, err, rx_data, rx_data_valid, rx_bit_en, b, e, d;
  blc_pkg::blc_bip_t          tx_line, rx_line;
  logic                       q[$];
  int                         fail_count = 0, n_tests = 0, seed = 89, k = 0;

  blc_top u_blc_top (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_data(tx_data), .tx_bit_en(tx_bit_en), .ext_error_trigger_pin(ext_pin), .tx_line(tx_line),
    .rx_line(rx_line), .rx_bit_en(rx_bit_en), .rx_data(rx_data), .rx_data_valid(rx_data_valid));
  blc_line_model u_blc_line_model (.pclk(pclk), .presetn(presetn), .tx_bit_en(tx_bit_en),
    .tx_line(tx_line), .rx_line(rx_line), .rx_bit_en(rx_bit_en));

  always #12.5 pclk = ~pclk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : tally_and_finish

  // one apb transfer, held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (n >= 20) fail_count++;
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    apb(1'h1, idx, d);
  endtask : wr

  task automatic rbit(input logic [7:0] idx, input int b);
    apb(1'h0, idx, 32'h0);
    e = rd[b];
  endtask : rbit

  task automatic strobes(input int n);
    repeat (n * 4) @(posedge pclk);
  endtask : strobes

  // framer side: one bit every fourth cycle, random, all ones or all zeros
  always @(posedge pclk) begin
    if (presetn) begin
      k <= (k + 1) % 4;
      tx_bit_en <= (k == 3);
      if (k == 3) begin
        b = (mode == 2'h0) ? 1'($random(seed)) : (mode == 2'h1);
        tx_data <= b;
        q.push_back(b);
      end
    end
  end

  // decoded bit comes back eight strobes after it was sent
  always @(posedge pclk) begin
    if (rx_data_valid === 1'h1) begin
      d = q.pop_front();
      if (chk_on) check(32'(rx_data), 32'(d));
    end
  end

  // random data through one coding setup, compared only once the pipe holds it
  task automatic run_data(input logic [31:0] tx, input logic [31:0] rx);
    wr(blc_pkg::IDX_TX_CTRL, tx);
    wr(blc_pkg::IDX_RX_CTRL, rx);
    strobes(16);
    chk_on <= 1'h1;
    strobes(200);
    chk_on <= 1'h0;
    $display("data test done");
  endtask : run_data

  initial begin
    repeat (8) q.push_back(1'h0);
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    apb(1'h0, blc_pkg::IDX_TX_CTRL, 32'h0);
    check(rd, 32'h0);
    apb(1'h0, blc_pkg::IDX_RX_CTRL, 32'h0);
    check(rd, 32'h0);
    apb(1'h0, 8'h8e, 32'h0);
    check({err, rd[30:0]}, 32'h80000000);
    // random words into the enable store; only the six low bits read back
    repeat (4) begin
      wv = $random(seed);
      wr(blc_pkg::IDX_RX_IRQ_EN, wv);
      apb(1'h0, blc_pkg::IDX_RX_IRQ_EN, 32'h0);
      check(rd, wv & 32'h3f);
    end
    $display("register test done");
    run_data(32'h0, 32'h6);
    wr(blc_pkg::IDX_LINE_MODE, 32'h1);
    run_data(32'h0, 32'h6);
    run_data(32'h10, 32'h7);
    // silent line with substitution off; marks first so the zero run starts after the clear
    mode <= 2'h1;
    wr(blc_pkg::IDX_RX_CTRL, 32'h6);
    wr(blc_pkg::IDX_PM_UPDATE, 32'h1);
    wr(blc_pkg::IDX_RX_STAT_L, 32'h3f);
    mode <= 2'h2;
    strobes(200);
    rbit(blc_pkg::IDX_RX_STAT, blc_pkg::ST_LOS_BIT);
    check(32'(e), 32'h1);
    rbit(blc_pkg::IDX_RX_STAT, blc_pkg::ST_EXZ_BIT);
    check(32'(e), 32'h1);
    rbit(blc_pkg::IDX_RX_STAT_L, blc_pkg::LT_EXZ_BIT);
    check(32'(e), 32'h1);
    wr(blc_pkg::IDX_RX_STAT_L, 32'h3f);
    rbit(blc_pkg::IDX_RX_STAT_L, blc_pkg::LT_LOS_BIT);
    check(32'(e), 32'h0);
    wr(blc_pkg::IDX_RX_CTRL, 32'h7);
    strobes(4);
    rbit(blc_pkg::IDX_RX_STAT, blc_pkg::ST_LOS_BIT);
    check(32'(e), 32'h0);
    rbit(blc_pkg::IDX_RX_STAT_L, blc_pkg::LT_LOS_BIT);
    check(32'(e), 32'h1);
    $display("signal absent test done");
    // substituted zeros stay clean until one excess-zero event is injected
    wr(blc_pkg::IDX_RX_CTRL, 32'h6);
    wr(blc_pkg::IDX_TX_CTRL, 32'h8);
    strobes(20);
    wr(blc_pkg::IDX_PM_UPDATE, 32'h1);
    wr(blc_pkg::IDX_RX_STAT_L, 32'h3f);
    strobes(30);
    rbit(blc_pkg::IDX_RX_STAT, blc_pkg::ST_EXZ_BIT);
    check(32'(e), 32'h0);
    wr(blc_pkg::IDX_TX_CTRL, 32'ha);
    strobes(20);
    rbit(blc_pkg::IDX_RX_STAT, blc_pkg::ST_EXZ_BIT);
    check(32'(e), 32'h1);
    rbit(blc_pkg::IDX_RX_STAT_L, blc_pkg::LT_EXCESS_ZERO_FLAG_BIT);
    check(32'(e), 32'h1);
    // one injected codeword gap is exactly one excessive-zero event
    wr(blc_pkg::IDX_PM_UPDATE, 32'h1);
    apb(1'h0, blc_pkg::IDX_EXZ_CNT, 32'h0);
    check(rd, 32'h1);
    $display("excess zero test done");
    // all ones: two register triggers, each dropped again, then the pin
    mode <= 2'h1;
    wr(blc_pkg::IDX_TX_CTRL, 32'h4);
    strobes(20);
    wr(blc_pkg::IDX_PM_UPDATE, 32'h1);
    wr(blc_pkg::IDX_RX_STAT_L, 32'h3f);
    repeat (2) begin
      wr(blc_pkg::IDX_TX_CTRL, 32'h6);
      strobes(20);
      wr(blc_pkg::IDX_TX_CTRL, 32'h4);
    end
    wr(blc_pkg::IDX_TX_CTRL, 32'h5);
    ext_pin <= 1'h1;
    strobes(20);
    ext_pin <= 1'h0;
    strobes(20);
    rbit(blc_pkg::IDX_RX_STAT, blc_pkg::ST_BPV_BIT);
    check(32'(e), 32'h1);
    apb(1'h0, blc_pkg::IDX_RX_STAT_L, 32'h0);
    check(rd & 32'h3f, 32'h6);
    wr(blc_pkg::IDX_PM_UPDATE, 32'h1);
    apb(1'h0, blc_pkg::IDX_BPV_CNT, 32'h0);
    check(rd, 32'h3);
    wr(blc_pkg::IDX_RX_STAT_L, 32'h3f);
    apb(1'h0, blc_pkg::IDX_RX_STAT_L, 32'h0);
    check(rd, 32'h0);
    $display("violation test done");
    tally_and_finish();
  end

  // watchdog well beyond the roughly four thousand three hundred cycles of the run
  initial begin
    #500000;
    fail_count++;
    tally_and_finish();
  end
endmodule : blc_top_tb
